// >>> src/sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// ==========================================
// Conversion result
`define SADC_RES_W 12
`define SADC_RES_MSB 11
`define SADC_CONV_CYC 12

// ==========================================
// Configuration word layout {single, odd, high-first}
`define SADC_CFG_W 3
`define SADC_CFG_SGL 2
`define SADC_CFG_ODD 1
`define SADC_CFG_HIGH_BIT_FIRST_ONLY 0
`define SADC_CFG_ONE_CH 3'h0

// ==========================================
// Host shift-clock timing
`define SADC_HALF_CYC_DEF 8
`define SADC_CFG_RELEASE 3
`define SADC_DATA0_TWO 6
`define SADC_DATA0_ONE 3
`define SADC_CNT_W 5

`endif

// >>> src/sadc_pkg.sv
`include "sadc_consts.svh"

package sadc_pkg;

    typedef enum logic [2:0] {
        SADC_D_ARM = 3'h0,
        SADC_D_CFG = 3'h1,
        SADC_D_HOLD = 3'h2,
        SADC_D_MSB = 3'h3,
        SADC_D_LSB = 3'h4,
        SADC_D_ZERO = 3'h5
    } sadc_dst_e;

    typedef enum logic [1:0] {
        SADC_H_IDLE = 2'h0,
        SADC_H_SETUP = 2'h1,
        SADC_H_RUN = 2'h2,
        SADC_H_FIN = 2'h3
    } sadc_hst_e;

    typedef logic [`SADC_RES_W-1:0] sadc_code_t;
    typedef logic [`SADC_CFG_W-1:0] sadc_cfg_t;
    typedef logic [`SADC_CNT_W-1:0] sadc_cnt_t;

    typedef struct packed {
        sadc_dst_e st;
        sadc_cnt_t cnt;
        sadc_cfg_t cfg;
        sadc_code_t res;
        logic d_o;
        logic d_oe;
        logic bias;
        logic awake;
        sadc_code_t code;
        logic vld;
    } sadc_dev_s;

    typedef struct packed {
        sadc_hst_e st;
        logic cs_n;
        logic sclk;
        logic d_o;
        logic d_oe;
        logic [15:0] div;
        sadc_cnt_t rcnt;
        sadc_cfg_t cfg;
        sadc_code_t sh;
        logic busy;
        logic done;
        sadc_code_t result;
    } sadc_host_s;

endpackage

// >>> src/sadc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sadc_if;
    logic cs_n;
    logic sclk;
    logic host_d;
    logic host_oe;
    logic dev_d;
    logic dev_oe;
    logic line;

    // Shared data wire with a weak pull-up when nobody drives it
    assign line = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);

    modport host (output cs_n, output sclk, output host_d, output host_oe, input line);
    modport dev (input cs_n, input sclk, input line, output dev_d, output dev_oe);
endinterface

`default_nettype wire

// >>> src/sadc_edge.sv
`timescale 1ns/1ps
`default_nettype none

module sadc_edge (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

`default_nettype wire

// >>> src/sadc_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"

// Functional notes
// RL1 - Drive on falling, sample on rising clock
// RL2 - One-channel: select falls, second pulse enables output (code enables output on the first fall)
// RL3 - One-channel: null bit before result
// RL4 - Select high resets serial logic
// RL5 - Two-channel: config in first, result after
// RL6 - Skip leading zeros; first one starts
// RL7 - Three config bits set mux, order, convert
// RL8 - Ignore input after config until reselect
// RL9 - Host order: single, odd, high-first
// RL10 - Mux decode single/differential with polarity
// RL11 - High-first only: then zeros
// RL12 - Otherwise low-first copy follows
// RL13 - One-channel always sends both copies
// RL14 - Shared wire driven on fourth fall
// RL15 - Twelve-bit unipolar straight binary
// RL16 - Zeros after result while clocked
// RL17 - Bias off after conversion, select low
// RL18 - Select high powers down
// RL19 - Hold on fall after last config
// RL20 - Conversion lasts twelve shift cycles
// RL21 - Output released while select high
module sadc_dev
    import sadc_pkg::*;
#(
    parameter bit TWO_CHAN = 1'b1
) (
    input wire logic core_clk,
    input wire logic nrst,
    sadc_if.dev bus,
    input wire sadc_code_t ch0_code,
    input wire sadc_code_t ch1_code,
    output sadc_code_t result_code,
    output logic result_valid,
    output logic bias_on,
    output logic powered
);
    // ==========================================
    // Build-time checks
    // Code bits are picked with four counter bits, so codes stop at sixteen
    if (`SADC_RES_W != `SADC_RES_MSB + 1 || `SADC_RES_W > 16) begin : g_bad_res
        $error("result width and top bit disagree");
    end
    if (`SADC_CONV_CYC != `SADC_RES_W || `SADC_CFG_W != 3) begin : g_bad_word
        $error("conversion length or configuration width unsupported");
    end
    if ((1 << `SADC_CNT_W) <= 2 * `SADC_RES_W) begin : g_bad_cnt
        $error("shift counter too narrow");
    end

    // ==========================================
    // Held-sample conversion
    // Analog levels arrive as codes; negative differences clip to zero
    function automatic sadc_code_t convert(input sadc_cfg_t cfg, input sadc_code_t a, input sadc_code_t b);
        sadc_code_t p;
        sadc_code_t m;
        p = cfg[`SADC_CFG_ODD] ? b : a; // see RL10
        m = cfg[`SADC_CFG_ODD] ? a : b;
        if (cfg[`SADC_CFG_SGL]) begin
            convert = p; // see RL10
        end else if (p > m) begin
            convert = p - m; // see RL15
        end else begin
            convert = '0;
        end
    endfunction

    // Code bit picked by a shift count; counts past the top read as zero
    function automatic logic res_bit(input sadc_code_t c, input sadc_cnt_t i);
        if (i > sadc_cnt_t'(`SADC_RES_MSB)) begin
            res_bit = 1'b0;
        end else begin
            res_bit = c[i[3:0]];
        end
    endfunction

    // ==========================================
    // Shift clock edges
    logic rise;
    logic fall;
    sadc_dev_s q;
    sadc_dev_s d;
    logic lsb_copy;

    // Edges are seen one core cycle late, so the far end must hold its bit through the high phase
    sadc_edge u_edge (
        .core_clk(core_clk),
        .nrst(nrst),
        .level(bus.sclk),
        .rise(rise),
        .fall(fall)
    );

    assign lsb_copy = !TWO_CHAN || !q.cfg[`SADC_CFG_HIGH_BIT_FIRST_ONLY]; // see RL12 see RL13

    // ==========================================
    // Serial state machine
    always_comb begin
        d = q;
        d.vld = 1'b0;
        d.awake = !bus.cs_n; // see RL18
        // Deselect wins over any edge seen in the same cycle
        if (bus.cs_n) begin
            d.st = SADC_D_ARM; // see RL4
            d.cnt = '0;
            d.d_oe = 1'b0; // see RL21
            d.d_o = 1'b0;
            d.bias = 1'b0; // see RL18
        end else begin
            unique case (q.st)
                SADC_D_ARM: begin
                    if (TWO_CHAN) begin
                        // Leading zeros fall through and are skipped
                        if (rise && bus.line) begin
                            d.st = SADC_D_CFG; // see RL6 see RL5
                            d.cnt = '0;
                        end
                    end else if (fall) begin
                        // Sampling spans the first pulse, hold at its fall
                        d.cfg = `SADC_CFG_ONE_CH;
                        d.res = convert(`SADC_CFG_ONE_CH, ch0_code, ch1_code);
                        d.bias = 1'b1;
                        d.d_oe = 1'b1; // see RL2
                        d.d_o = 1'b0; // see RL3
                        d.st = SADC_D_MSB;
                        d.cnt = '0;
                    end
                end
                SADC_D_CFG: begin
                    if (rise) begin
                        d.cfg = {q.cfg[`SADC_CFG_W-2:0], bus.line}; // see RL1 see RL7 see RL9
                        d.cnt = q.cnt + 1'b1;
                        if (q.cnt == sadc_cnt_t'(`SADC_CFG_W - 1)) begin
                            d.st = SADC_D_HOLD; // see RL8
                        end
                    end
                end
                SADC_D_HOLD: begin
                    if (fall) begin
                        // Sample frozen here; later input moves cannot reach the code
                        d.res = convert(q.cfg, ch0_code, ch1_code); // see RL19
                        d.bias = 1'b1;
                        d.d_oe = 1'b1; // see RL14
                        d.d_o = 1'b0;
                        d.st = SADC_D_MSB;
                        d.cnt = '0;
                    end
                end
                SADC_D_MSB: begin
                    if (fall) begin
                        d.d_o = res_bit(q.res, sadc_cnt_t'(`SADC_RES_MSB) - q.cnt); // see RL1 see RL11
                        d.cnt = q.cnt + 1'b1;
                        // Bias is not needed to replay bits already held
                        if (q.cnt == sadc_cnt_t'(`SADC_CONV_CYC - 1)) begin
                            d.bias = 1'b0; // see RL17 see RL20
                            d.vld = 1'b1;
                            d.code = q.res;
                            d.cnt = sadc_cnt_t'(1);
                            d.st = lsb_copy ? SADC_D_LSB : SADC_D_ZERO;
                        end
                    end
                end
                SADC_D_LSB: begin
                    // Last bit is shared between the two copies
                    if (fall) begin
                        d.d_o = res_bit(q.res, q.cnt); // see RL12
                        d.cnt = q.cnt + 1'b1;
                        if (q.cnt == sadc_cnt_t'(`SADC_RES_MSB)) begin
                            d.st = SADC_D_ZERO;
                        end
                    end
                end
                SADC_D_ZERO: begin
                    if (fall) begin
                        d.d_o = 1'b0; // see RL16
                    end
                end
                default: begin
                    d.st = SADC_D_ARM;
                end
            endcase
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs, all straight from the state register

    assign bus.dev_d = q.d_o;
    assign bus.dev_oe = q.d_oe;
    assign result_code = q.code;
    assign result_valid = q.vld;
    assign bias_on = q.bias;
    assign powered = q.awake;
endmodule

`default_nettype wire

// >>> src/sadc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"

module sadc_host
    import sadc_pkg::*;
#(
    parameter bit TWO_CHAN = 1'b1,
    parameter int HALF_CYC = `SADC_HALF_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    sadc_if.host bus,
    input wire logic start,
    input wire logic cfg_single,
    input wire logic cfg_odd,
    input wire logic cfg_high_first_only,
    output logic busy,
    output logic done,
    output sadc_code_t result
);
    // ==========================================
    // Parameter check
    if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_bad_half
        $error("HALF_CYC out of range");
    end

    localparam sadc_cnt_t DATA0 = sadc_cnt_t'(TWO_CHAN ? `SADC_DATA0_TWO : `SADC_DATA0_ONE);

    sadc_host_s q;
    sadc_host_s d;
    logic tick;
    sadc_cnt_t k;
    sadc_cnt_t last;

    // Second copy is clocked through but not kept
    assign tick = (q.div == 16'(HALF_CYC - 1));
    assign k = q.rcnt + 1'b1;
    assign last = DATA0 + sadc_cnt_t'(`SADC_RES_MSB) +
                  (q.cfg[`SADC_CFG_HIGH_BIT_FIRST_ONLY] ? sadc_cnt_t'(0) : sadc_cnt_t'(`SADC_RES_MSB));

    // ==========================================
    // Divider and transfer sequencer
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.div = (q.st == SADC_H_IDLE || tick) ? '0 : q.div + 1'b1;
        unique case (q.st)
            SADC_H_IDLE: begin
                if (start) begin
                    d.cs_n = 1'b0;
                    d.cfg = {cfg_single, cfg_odd, cfg_high_first_only};
                    d.rcnt = '0;
                    d.busy = 1'b1;
                    d.d_oe = TWO_CHAN; // see RL6
                    d.d_o = TWO_CHAN;
                    d.st = SADC_H_SETUP;
                end
            end
            SADC_H_SETUP: begin
                if (tick) begin
                    d.st = SADC_H_RUN;
                end
            end
            SADC_H_RUN: begin
                if (tick && !q.sclk) begin
                    d.sclk = 1'b1;
                    d.rcnt = k;
                    if (k >= DATA0 && k < DATA0 + sadc_cnt_t'(`SADC_RES_W)) begin
                        d.sh = {q.sh[`SADC_RES_W-2:0], bus.line}; // see RL1
                    end
                    if (k == last) begin
                        d.st = SADC_H_FIN; // see RL13
                    end
                end else if (tick) begin
                    d.sclk = 1'b0;
                    if (q.d_oe && q.rcnt <= sadc_cnt_t'(`SADC_CFG_RELEASE)) begin
                        d.d_o = q.cfg[`SADC_CFG_RELEASE - q.rcnt[1:0]]; // see RL9 see RL1
                    end
                    // Held through the fourth high phase, since the far end sees edges a cycle late
                    if (q.rcnt == sadc_cnt_t'(`SADC_CFG_RELEASE + 1)) begin
                        d.d_oe = 1'b0; // see RL14
                    end
                end
            end
            SADC_H_FIN: begin
                if (tick) begin
                    d.cs_n = 1'b1; // see RL4
                    d.sclk = 1'b0;
                    d.d_oe = 1'b0;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.result = q.sh;
                    d.st = SADC_H_IDLE;
                end
            end
            default: begin
                d.st = SADC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.cs_n = q.cs_n;
    assign bus.sclk = q.sclk;
    assign bus.host_d = q.d_o;
    assign bus.host_oe = q.d_oe;
    assign busy = q.busy;
    assign done = q.done;
    assign result = q.result;
endmodule

`default_nettype wire

// >>> verification/sadc_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Wire checks on the two-channel link
module sadc_link_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_d,
    input wire logic host_oe,
    input wire logic dev_d,
    input wire logic dev_oe,
    input wire logic line
);
    logic [2:0] fcnt;

    // Falls since select, saturating so a long run cannot wrap to four
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fcnt <= 3'h0;
        end else if (cs_n) begin
            fcnt <= 3'h0;
        end else if ($fell(sclk) && fcnt != 3'h7) begin
            fcnt <= fcnt + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_oe_fourth_fall: assert property (
        $rose(dev_oe) |-> fcnt == 3'h4) else $error("output enabled off the fourth fall");
    a_no_clash: assert property (
        !(dev_oe && host_oe)) else $error("both ends drive the line");
    a_null_low: assert property (
        $rose(dev_oe) |-> !dev_d) else $error("first driven bit not low");
    a_dev_on_fall: assert property (
        $changed(dev_d) && $past(dev_oe) && dev_oe |-> !sclk) else $error("device bit moved with clock high");
    a_host_on_fall: assert property (
        $changed(host_d) && $past(host_oe) && host_oe |-> !sclk) else $error("host bit moved with clock high");
    a_oe_needs_sel: assert property (
        $rose(dev_oe) |-> !cs_n) else $error("output enabled while deselected");
    a_oe_off_desel: assert property (
        $rose(cs_n) |-> ##[1:3] !dev_oe) else $error("output kept after select rose");
    a_idle_desel: assert property (
        cs_n && $past(cs_n, 3) |-> !dev_oe) else $error("output driven while powered down");
    a_start_bit: assert property (
        $fell(cs_n) |-> ##[0:1] host_oe && host_d) else $error("no start bit after select");
    a_line_follows: assert property (
        dev_oe |-> line == dev_d) else $error("shared wire not showing device bit");
endmodule

`default_nettype wire

// >>> verification/tb_sampling_adc_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sampling_adc_serial_port
    import sadc_pkg::*;
();
    logic core_clk, nrst, start, sgl, odd, hfo;
    logic [1:0] drop;
    sadc_code_t c0, c1, r2, r1, rc2, rc1;
    logic busy2, done2, busy1, done1, v2, v1, b2, b1, p2, p1;
    logic q2[$];
    logic q1[$];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0;
    int i;
    sadc_code_t ta[8] = '{12'hfff, 12'h000, 12'h9a5, 12'h123, 12'h800, 12'h7ff, 12'h5a5, 12'h001};
    sadc_code_t tb[8] = '{12'h000, 12'hfff, 12'h3c6, 12'h123, 12'h7ff, 12'h800, 12'ha5a, 12'hffe};

    // ========================================
    // Two-channel pair and one-channel pair
    sadc_if u_sadc_if ();
    sadc_if u_sadc_if_one ();
    sadc_host #(.TWO_CHAN(1'b1), .HALF_CYC(8)) u_sadc_host (.core_clk, .nrst, .bus(u_sadc_if), .start,
        .cfg_single(sgl), .cfg_odd(odd), .cfg_high_first_only(hfo), .busy(busy2), .done(done2), .result(r2));
    sadc_dev u_sadc_dev (.core_clk, .nrst, .bus(u_sadc_if), .ch0_code(c0), .ch1_code(c1),
        .result_code(rc2), .result_valid(v2), .bias_on(b2), .powered(p2));
    sadc_host #(.TWO_CHAN(1'b0), .HALF_CYC(8)) u_sadc_host_one (.core_clk, .nrst, .bus(u_sadc_if_one), .start,
        .cfg_single(sgl), .cfg_odd(odd), .cfg_high_first_only(hfo), .busy(busy1), .done(done1), .result(r1));
    sadc_dev #(.TWO_CHAN(1'b0)) u_sadc_dev_one (.core_clk, .nrst, .bus(u_sadc_if_one), .ch0_code(c0),
        .ch1_code(c1), .result_code(rc1), .result_valid(v1), .bias_on(b1), .powered(p1));
    sadc_link_monitor u_sadc_link_monitor (.core_clk, .nrst, .cs_n(u_sadc_if.cs_n), .sclk(u_sadc_if.sclk),
        .host_d(u_sadc_if.host_d), .host_oe(u_sadc_if.host_oe), .dev_d(u_sadc_if.dev_d),
        .dev_oe(u_sadc_if.dev_oe), .line(u_sadc_if.line));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ========================================
    // Wire capture on the receiving edge
    always @(posedge u_sadc_if.sclk) if (u_sadc_if.dev_oe) q2.push_back(u_sadc_if.line);
    always @(posedge u_sadc_if_one.sclk) if (u_sadc_if_one.dev_oe) q1.push_back(u_sadc_if_one.line);
    always @(negedge b2) if (nrst && !u_sadc_if.cs_n) drop[0] = 1'b1;
    always @(negedge b1) if (nrst && !u_sadc_if_one.cs_n) drop[1] = 1'b1;
    always @(posedge core_clk) pulses += v2 + v1 + done2 + done1;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            report_and_stop();
        end
    end

    task cmp(input string n, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Null, high-first copy, then low-first copy sharing the last bit
    task automatic chk(input string n, input logic s[$], input sadc_code_t c, input logic h);
        int k;
        logic e;
        cmp({n, " length"}, h ? 12'h00d : 12'h018, 12'(s.size()));
        for (k = 0; k < s.size(); k++) begin
            e = (k == 0) ? 1'b0 : (k <= 12) ? c[12 - k] : c[k - 12];
            cmp(n, {11'h0, e}, {11'h0, s[k]});
        end
    endtask

    task automatic run(input logic [2:0] m, input sadc_code_t a, input sadc_code_t b);
        sadc_code_t e1, e2;
        int n = 0;
        e1 = (a > b) ? a - b : 12'h000;
        e2 = m[2] ? (m[1] ? b : a) : (m[1] ? ((b > a) ? b - a : 12'h000) : e1);
        @(negedge core_clk);
        {sgl, odd, hfo, c0, c1, start, drop} = {m, a, b, 3'b100};
        pulses = 0;
        q2.delete();
        q1.delete();
        @(negedge core_clk);
        start = 1'b0;
        @(negedge core_clk);
        cmp("powered on", 12'h001, {11'h0, p2 & p1});
        while ((busy2 || busy1) && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        cmp("result two", e2, r2);
        cmp("device code", e2, rc2);
        cmp("result one", e1, r1);
        chk("two wire", q2, e2, m[0]);
        chk("one wire", q1, e1, m[0]);
        cmp("bias drop", 12'h003, {10'h0, drop});
        cmp("device code one", e1, rc1);
        // Idle gap also lets the device see select high and power down, and the done pulses get counted
        repeat (3) @(negedge core_clk);
        cmp("powered", 12'h000, {11'h0, p2 | p1});
        cmp("valid and done pulses", 12'h004, 12'(pulses));
    endtask

    task report_and_stop;
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        {nrst, start, sgl, odd, hfo, c0, c1} = '0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        for (i = 0; i < 8; i++) begin
            run(3'(i), ta[i], tb[i]);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
